// *** hdl/rom_pkg.sv ***
// constants shared by the reader operation mode register bank
package rom_pkg;
    // register addresses and widths
    localparam int         ADDR_W          = 6;
    localparam int         DATA_W          = 8;
    localparam logic [5:0] ADDR_OP_CTRL    = 6'h02;
    localparam logic [5:0] ADDR_MODE_DEF   = 6'h03;
    localparam logic [5:0] ADDR_RATE_DEF   = 6'h04;
    // reset values
    localparam logic [7:0] RST_OP_CTRL     = 8'h00;
    localparam logic [7:0] RST_MODE_DEF    = 8'h08;
    localparam logic [7:0] RST_RATE_DEF    = 8'h00;
    // operation control fields
    localparam int         OP_READY_BIT    = 7;
    localparam int         OP_RX_ON_BIT    = 6;
    localparam int         OP_ONE_CHAN_BIT = 5;
    localparam int         OP_MANUAL_BIT   = 4;
    localparam int         OP_TX_ON_BIT    = 3;
    localparam int         OP_WAKEUP_BIT   = 2;
    localparam logic [7:0] OP_USED_MASK    = 8'hFC;
    // mode definition fields
    localparam int         MD_TARGET_BIT   = 7;
    localparam int         MD_CODE_HI      = 6;
    localparam int         MD_CODE_LO      = 3;
    localparam int         MD_AUTO_CA_BIT  = 0;
    localparam logic [7:0] MD_USED_MASK    = 8'hF9;
    // bit rate fields
    localparam int         BR_TX_HI        = 7;
    localparam int         BR_TX_LO        = 4;
    localparam int         BR_RX_HI        = 3;
    localparam int         BR_RX_LO        = 0;
    // initiator protocol codes
    localparam logic [3:0] INI_P2P_ACTIVE  = 4'h0;
    localparam logic [3:0] INI_TYPE_A      = 4'h1;
    localparam logic [3:0] INI_TYPE_B      = 4'h2;
    localparam logic [3:0] INI_PROP_CARD   = 4'h3;
    localparam logic [3:0] INI_TYPE1_TAG   = 4'h4;
    localparam logic [3:0] INI_SUBC_STREAM = 4'hE;
    localparam logic [3:0] INI_BPSK_STREAM = 4'hF;
    // target protocol codes
    localparam logic [3:0] TGT_P2P_DETECT  = 4'h0;
    localparam logic [3:0] TGT_P2P_NORMAL  = 4'h1;
    // rate codes, carrier divided by 128 down to 2
    localparam logic [3:0] RATE_FC128      = 4'h0;
    localparam logic [3:0] RATE_FC16       = 4'h3;
    localparam logic [3:0] RATE_FC8        = 4'h4;
    localparam logic [3:0] RATE_FC4        = 4'h5;
    localparam logic [3:0] RATE_FC2        = 4'h6;
    // one-hot protocol selection, one bit per supported mode
    typedef enum logic [8:0] {
        ROM_PROTO_NONE     = 9'h000,
        ROM_PROTO_INI_P2P  = 9'h001,
        ROM_PROTO_INI_A    = 9'h002,
        ROM_PROTO_INI_B    = 9'h004,
        ROM_PROTO_INI_PROP = 9'h008,
        ROM_PROTO_INI_T1   = 9'h010,
        ROM_PROTO_INI_SUBC = 9'h020,
        ROM_PROTO_INI_BPSK = 9'h040,
        ROM_PROTO_TGT_DET  = 9'h080,
        ROM_PROTO_TGT_NORM = 9'h100
    } rom_proto_t;
endpackage

// *** hdl/rom_rate_decode.sv ***
// decodes one four-bit rate code into a one-hot carrier fraction
`timescale 1ns/1ps
module rom_rate_decode
    import rom_pkg::*;
(
    input  wire logic [3:0] i_code,       // four-bit rate code
    output logic      [6:0] o_fraction,   // one-hot fc/128 .. fc/2
    output logic            o_very_high,  // code above fc/16
    output logic            o_valid       // code is defined
);
    // codes 0..6 map to fc/128 .. fc/2; all others unused
    always_comb
    begin
        o_fraction  = 7'h00;
        o_valid     = (i_code <= RATE_FC2);
        o_very_high = o_valid && (i_code >= RATE_FC8);
        if (o_valid)
        begin
            o_fraction = 7'(7'h01 << i_code[2:0]);
        end
    end
endmodule

// *** hdl/rom_regs.sv ***
// operation control, mode definition and bit rate register bank
// Summary of operation
// - bit 7 enables oscillator, regulator (ready)
// - bit 6 enables receive operation
// - bit 5 zero: both channels; one: picked
// - bit 4 chooses automatic or manual selection
// - bit 3 enables transmit; field-on sets it
// - active peer mode clears transmit after send
// - bit 2 enters wake-up mode
// - operation control defaults only at power-up
// - mode bit 7 picks initiator or target
// - initiator protocol codes decode as listed
// - target codes: detect-rate or normal peer
// - unsupported protocol code disables tx and rx
// - bit 0 starts collision avoidance on field-off
// - mode and rate default on set-default, 08h and 00h
// - rate bits 7:4 transmit, 3:0 receive
// - rate codes decode to fc/128 .. fc/2
// - very high tx only type B; rx fc/4
// - unsupported rate code disables tx and rx
// - go-normal command loads detected bit rate
`timescale 1ns/1ps
module rom_regs
    import rom_pkg::*;
#(
    parameter int ADDR_WIDTH = rom_pkg::ADDR_W,  // register address bits
    parameter int DATA_WIDTH = rom_pkg::DATA_W   // register data bits
)
(
    input  wire logic                  i_mclk,           // device clock
    input  wire logic                  i_arst_n,         // power-up reset
    input  wire logic                  i_wr_en,          // register write
    input  wire logic [ADDR_WIDTH-1:0] i_addr,           // register address
    input  wire logic [DATA_WIDTH-1:0] i_wdata,          // write data
    output logic      [DATA_WIDTH-1:0] o_rdata,          // read data
    input  wire logic                  i_set_default,    // set-default cmd
    input  wire logic                  i_field_on_cmd,   // field-on cmd
    input  wire logic                  i_tx_done,        // transmit finished
    input  wire logic                  i_go_normal_cmd,  // go normal peer
    input  wire logic [3:0]            i_detected_rate,  // detected rate
    input  wire logic                  i_ext_field_off,  // ext field gone
    input  wire logic                  i_channel_pick,   // channel pick bit
    output logic                       o_ready_mode,     // osc + regulator
    output logic                       o_rx_enable,      // receiver active
    output logic                       o_tx_enable,      // transmitter on
    output logic                       o_am_active,      // AM channel on
    output logic                       o_pm_active,      // PM channel on
    output logic                       o_auto_chan_sel,  // auto selection
    output logic                       o_wakeup_mode_on, // wake-up mode
    output logic                       o_target_role,    // target role
    output rom_pkg::rom_proto_t        o_protocol,       // one-hot protocol
    output logic [6:0]                 o_tx_fraction,    // tx carrier frac
    output logic [6:0]                 o_rx_fraction,    // rx carrier frac
    output logic                       o_config_bad,     // tx/rx disabled
    output logic                       o_collision_start // start RFCA pulse
);
    // the address map and the eight-bit fields live in the package, so
    // any other width would silently lose bits; refuse it up front
    if (ADDR_WIDTH != ADDR_W || DATA_WIDTH != DATA_W)
    begin : g_width_check
        $error("rom_regs: width parameters must match the package");
    end

    // all state of the bank, held in one record so the reset branch
    // and the next-state logic cannot drift apart field by field
    typedef struct packed {
        logic [7:0] op_ctrl;
        logic [7:0] mode_def;
        logic [7:0] rate_def;
        logic [7:0] rdata;
        logic       field_off_d;
        logic       ca_start;
        logic       rx_en;
        logic       tx_en;
        logic       am_on;
        logic       pm_on;
        logic       auto_sel;
        rom_proto_t proto;
        logic [6:0] tx_frac;
        logic [6:0] rx_frac;
        logic       bad;
    } rom_state_t;

    // registered state and its next value
    rom_state_t st_ff;
    rom_state_t nxt_st;

    // protocol decode results
    logic [3:0] code;
    logic       peer_mode;
    // rate decode results
    logic [3:0] tx_code;
    logic [3:0] rx_code;
    logic [6:0] tx_frac;
    logic [6:0] rx_frac;
    logic       tx_vh;
    logic       rx_vh;
    logic       tx_ok;
    logic       rx_ok;
    logic       proto_ok;
    logic       rate_ok;
    rom_proto_t proto;

    // fields picked out of the stored registers
    assign code    = st_ff.mode_def[MD_CODE_HI:MD_CODE_LO];
    // only the active peer modes give the transmitter back on their own
    assign peer_mode = (proto == ROM_PROTO_INI_P2P)
                       || (proto == ROM_PROTO_TGT_DET)
                       || (proto == ROM_PROTO_TGT_NORM);
    assign tx_code = st_ff.rate_def[BR_TX_HI:BR_TX_LO];
    assign rx_code = st_ff.rate_def[BR_RX_HI:BR_RX_LO];

    // one decoder per rate direction; both see the raw nibble, so an
    // unused code shows up as an all-zero fraction as well as a flag
    rom_rate_decode u_tx_rate
    (
        .i_code      (tx_code),
        .o_fraction  (tx_frac),
        .o_very_high (tx_vh),
        .o_valid     (tx_ok)
    );

    rom_rate_decode u_rx_rate
    (
        .i_code      (rx_code),
        .o_fraction  (rx_frac),
        .o_very_high (rx_vh),
        .o_valid     (rx_ok)
    );

    // protocol decode depends on the role bit; a code that the role
    // does not list falls to none and gates both directions
    always_comb
    begin
        proto = ROM_PROTO_NONE;
        if (st_ff.mode_def[MD_TARGET_BIT])
        begin
            case (code)
                TGT_P2P_DETECT: proto = ROM_PROTO_TGT_DET;
                TGT_P2P_NORMAL: proto = ROM_PROTO_TGT_NORM;
                default:        proto = ROM_PROTO_NONE;
            endcase
        end
        else
        begin
            case (code)
                INI_P2P_ACTIVE:  proto = ROM_PROTO_INI_P2P;
                INI_TYPE_A:      proto = ROM_PROTO_INI_A;
                INI_TYPE_B:      proto = ROM_PROTO_INI_B;
                INI_PROP_CARD:   proto = ROM_PROTO_INI_PROP;
                INI_TYPE1_TAG:   proto = ROM_PROTO_INI_T1;
                INI_SUBC_STREAM: proto = ROM_PROTO_INI_SUBC;
                INI_BPSK_STREAM: proto = ROM_PROTO_INI_BPSK;
                default:         proto = ROM_PROTO_NONE;
            endcase
        end
        proto_ok = (proto != ROM_PROTO_NONE);
    end

    // rate legality; very high rx only at fc/4, tx only for type B
    // the check reads the decoded protocol, so a mode change alone can
    // turn a stored rate bad without any write to the rate register
    always_comb
    begin
        rate_ok = tx_ok && rx_ok;
        if (tx_vh && (proto != ROM_PROTO_INI_B))
        begin
            rate_ok = 1'b0;
        end
        if (rx_vh && (rx_code != RATE_FC4))
        begin
            rate_ok = 1'b0;
        end
    end

    // next-state: register writes, command side effects, decode
    // later assignments win: a command overrides a host write in the
    // same cycle, go-normal overrides set-default on the rate register,
    // and field-on overrides the tx-done clear so a fresh field is kept
    always_comb
    begin
        nxt_st = st_ff;
        // host writes; unused bits stored as zero, while the rate
        // register keeps all eight bits so a bad code reads back as is
        if (i_wr_en)
        begin
            case (i_addr)
                ADDR_OP_CTRL:
                    nxt_st.op_ctrl = i_wdata & OP_USED_MASK;
                ADDR_MODE_DEF:
                    nxt_st.mode_def = i_wdata & MD_USED_MASK;
                ADDR_RATE_DEF:
                    nxt_st.rate_def = i_wdata;
                default:
                    nxt_st = nxt_st;
            endcase
        end
        // operation control is not touched by set-default; it keeps
        // the power state, which a mode reset must not drop
        if (i_set_default)
        begin
            nxt_st.mode_def = RST_MODE_DEF;
            nxt_st.rate_def = RST_RATE_DEF;
        end
        // detected rate copied to both directions; the detector reports
        // one code, so receive and transmit start out equal
        if (i_go_normal_cmd)
        begin
            nxt_st.rate_def = {i_detected_rate, i_detected_rate};
        end
        // the tx-done clear yields to a field-on in the same cycle
        if (i_tx_done && peer_mode)
        begin
            nxt_st.op_ctrl[OP_TX_ON_BIT] = 1'b0;
        end
        // field-on sets the transmitter bit after any clear above
        if (i_field_on_cmd)
        begin
            nxt_st.op_ctrl[OP_TX_ON_BIT] = 1'b1;
        end
        // field-off edge detector, input from same clock domain; the
        // delayed copy resets low, which is safe because the enable bit
        // resets low too and no false start can follow reset
        nxt_st.field_off_d = i_ext_field_off;
        nxt_st.ca_start = st_ff.mode_def[MD_AUTO_CA_BIT]
                          && i_ext_field_off
                          && !st_ff.field_off_d;
        // registered decode outputs; the stored bits are kept as written,
        // only the enables are gated, so a fixed setting needs no rewrite
        nxt_st.bad = !(proto_ok && rate_ok);
        nxt_st.rx_en = st_ff.op_ctrl[OP_RX_ON_BIT]
                       && proto_ok && rate_ok;
        nxt_st.tx_en = st_ff.op_ctrl[OP_TX_ON_BIT]
                       && proto_ok && rate_ok;
        // one channel: the pick bit chooses AM (0) or PM (1); auto
        // selection is meaningless then and is forced off
        if (st_ff.op_ctrl[OP_ONE_CHAN_BIT])
        begin
            nxt_st.am_on    = !i_channel_pick;
            nxt_st.pm_on    = i_channel_pick;
            nxt_st.auto_sel = 1'b0;
        end
        else
        begin
            nxt_st.am_on    = 1'b1;
            nxt_st.pm_on    = 1'b1;
            nxt_st.auto_sel = !st_ff.op_ctrl[OP_MANUAL_BIT];
        end
        // the one-hot code makes every mode a single bit to test
        nxt_st.proto   = proto;
        nxt_st.tx_frac = tx_frac;
        nxt_st.rx_frac = rx_frac;
        // read data, unmapped addresses read zero; one cycle of latency
        // keeps the read path a plain flop behind the address decode
        case (i_addr)
            ADDR_OP_CTRL:  nxt_st.rdata = st_ff.op_ctrl;
            ADDR_MODE_DEF: nxt_st.rdata = st_ff.mode_def;
            ADDR_RATE_DEF: nxt_st.rdata = st_ff.rate_def;
            default:       nxt_st.rdata = 8'h00;
        endcase
    end

    // only power-up reset defaults operation control; the derived
    // outputs reset to what the default mode and rate decode to, so
    // nothing glitches on the first edge after release
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            st_ff          <= '0;
            st_ff.op_ctrl  <= RST_OP_CTRL;
            st_ff.mode_def <= RST_MODE_DEF;
            st_ff.rate_def <= RST_RATE_DEF;
            st_ff.am_on    <= 1'b1;
            st_ff.pm_on    <= 1'b1;
            st_ff.auto_sel <= 1'b1;
            st_ff.proto    <= ROM_PROTO_INI_A;
            st_ff.tx_frac  <= 7'h01;
            st_ff.rx_frac  <= 7'h01;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from flip-flops; role and the two direct bits
    // follow the register, the decoded ones trail it by one cycle
    assign o_rdata           = st_ff.rdata;
    assign o_ready_mode      = st_ff.op_ctrl[OP_READY_BIT];
    assign o_wakeup_mode_on  = st_ff.op_ctrl[OP_WAKEUP_BIT];
    assign o_rx_enable       = st_ff.rx_en;
    assign o_tx_enable       = st_ff.tx_en;
    assign o_am_active       = st_ff.am_on;
    assign o_pm_active       = st_ff.pm_on;
    assign o_auto_chan_sel   = st_ff.auto_sel;
    assign o_target_role     = st_ff.mode_def[MD_TARGET_BIT];
    assign o_protocol        = st_ff.proto;
    assign o_tx_fraction     = st_ff.tx_frac;
    assign o_rx_fraction     = st_ff.rx_frac;
    assign o_config_bad      = st_ff.bad;
    assign o_collision_start = st_ff.ca_start;
endmodule

// *** verif/rom_host_model.sv ***
// host model: drives the register port as the controller would
`timescale 1ns/1ps
module rom_host_model (
    input  wire logic       i_mclk,          // device clock
    input  wire logic [7:0] i_rdata,         // read data
    output logic            o_wr_en = 1'b0,  // write strobe
    output logic      [5:0] o_addr  = 6'h00, // register address
    output logic      [7:0] o_wdata = 8'h00  // write data
);
    // after the strobe the data shows the inverse, so a late sample fails
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        o_wr_en <= 1'b1;
        o_addr  <= a;
        o_wdata <= d;
        @(posedge i_mclk);
        o_wr_en <= 1'b0;
        o_wdata <= ~d;
    endtask
    // read data trails the address by one edge
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        o_addr <= a;
        repeat (2) @(posedge i_mclk);
        #1;
        d = i_rdata;
    endtask
endmodule

// *** verif/rom_regs_chk.sv ***
// assertion checker for the operation mode register bank
`timescale 1ns/1ps
module rom_regs_chk
    import rom_pkg::*;
(
    input  wire logic       i_mclk,            // device clock
    input  wire logic       i_arst_n,          // power-up reset
    input  wire logic       i_ext_field_off,   // external field gone
    input  wire logic       o_rx_enable,       // receiver on
    input  wire logic       o_tx_enable,       // transmitter on
    input  wire logic       o_am_active,       // AM channel on
    input  wire logic       o_pm_active,       // PM channel on
    input  wire logic       o_auto_chan_sel,   // automatic selection
    input  wire logic       o_target_role,     // target role
    input  wire rom_proto_t o_protocol,        // one-hot protocol
    input  wire logic [6:0] o_tx_fraction,     // tx carrier fraction
    input  wire logic [6:0] o_rx_fraction,     // rx carrier fraction
    input  wire logic       o_config_bad,      // tx/rx disabled
    input  wire logic       o_collision_start  // collision avoid pulse
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    // collision start is one pulse, and only near a field loss
    property p_ca_pulse; o_collision_start |=> !o_collision_start; endproperty
    a_ca_pulse: assert property (p_ca_pulse) else $error("ca long");
    property p_ca_cause;
        o_collision_start |-> i_ext_field_off || $past(i_ext_field_off);
    endproperty
    a_ca_cause: assert property (p_ca_cause) else $error("ca cause");
    // a bad setting must silence both directions
    property p_gate; o_config_bad |-> !o_tx_enable && !o_rx_enable; endproperty
    a_gate: assert property (p_gate) else $error("tx/rx on");
    // at least one receive channel, and auto only with both
    property p_chan; o_am_active || o_pm_active; endproperty
    a_chan: assert property (p_chan) else $error("no channel");
    property p_auto; o_auto_chan_sel |-> o_am_active && o_pm_active; endproperty
    a_auto: assert property (p_auto) else $error("auto alone");
    // the decoded protocol trails the role bit by one cycle
    property p_role;
        o_target_role && $past(o_target_role) |-> o_protocol inside
            {ROM_PROTO_NONE, ROM_PROTO_TGT_DET, ROM_PROTO_TGT_NORM};
    endproperty
    a_role: assert property (p_role) else $error("role code");
    property p_none; o_protocol == ROM_PROTO_NONE |-> o_config_bad; endproperty
    a_none: assert property (p_none) else $error("none ok");
    // very high rates are legal only for type B tx and fc/4 rx
    property p_vh;
        ((|o_tx_fraction[6:4]) && o_protocol != ROM_PROTO_INI_B)
            || o_rx_fraction[4] || o_rx_fraction[6] |-> o_config_bad;
    endproperty
    a_vh: assert property (p_vh) else $error("vh ok");
    property p_frac;
        o_tx_fraction == 7'h00 || o_rx_fraction == 7'h00 |-> o_config_bad;
    endproperty
    a_frac: assert property (p_frac) else $error("rate ok");
    c_ca: cover property (o_collision_start);
    c_bad: cover property (o_config_bad);
    c_tgt: cover property (o_target_role && !o_config_bad);
endmodule
bind rom_regs rom_regs_chk rom_regs_chk_i (.*);

// *** verif/tb_top.sv ***
// self-checking bench for the operation mode register bank
`timescale 1ns/1ps
module tb_top;
    import rom_pkg::*;
    typedef struct packed {
        logic [7:0] op, md, br;
        logic [8:0] pr;
        logic [6:0] tf, rf;
        logic [7:0] fl;
    } rom_row_t;
    logic       i_mclk   = 1'b0;
    logic       i_arst_n = 1'b0;
    logic [3:0] cmd      = 4'h0;
    logic       fld_off  = 1'b0;
    logic       pick     = 1'b0;
    logic       wr_en, rdy, wake, rxe, txe, am, pm, aut, targ, bad, ca;
    logic [5:0] addr;
    logic [7:0] wdata, rdata, rb;
    logic [6:0] txf, rxf;
    rom_proto_t proto;
    int         err_total = 0;
    int         samples_checked = 0;
    int         ca_cnt = 0;
    // op, mode, rate, protocol, tx/rx fraction, flags
    rom_row_t   rows [15] = '{
        '{8'hC8,8'h08,8'h00,9'h002,7'h01,7'h01,8'hBE},
        '{8'h78,8'h00,8'h11,9'h001,7'h02,7'h02,8'h38},
        '{8'h58,8'h10,8'h44,9'h004,7'h10,7'h10,8'h0D},
        '{8'h48,8'h10,8'h55,9'h004,7'h20,7'h20,8'h3E},
        '{8'h48,8'h08,8'h50,9'h002,7'h20,7'h01,8'h0F},
        '{8'h48,8'h18,8'h33,9'h008,7'h08,7'h08,8'h3E},
        '{8'h48,8'h20,8'h22,9'h010,7'h04,7'h04,8'h3E},
        '{8'h48,8'h70,8'h00,9'h020,7'h01,7'h01,8'h3E},
        '{8'h48,8'h78,8'h00,9'h040,7'h01,7'h01,8'h3E},
        '{8'h48,8'h80,8'h00,9'h080,7'h01,7'h01,8'h3E},
        '{8'h48,8'h88,8'h00,9'h100,7'h01,7'h01,8'h3E},
        '{8'h48,8'h90,8'h00,9'h000,7'h01,7'h01,8'h0F},
        '{8'h48,8'h28,8'h00,9'h000,7'h01,7'h01,8'h0F},
        '{8'h48,8'h08,8'h77,9'h002,7'h00,7'h00,8'h0F},
        '{8'h04,8'h08,8'h00,9'h002,7'h01,7'h01,8'h4E}};
    always #10 i_mclk = ~i_mclk;
    rom_regs rom_regs_i (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
        .i_wr_en(wr_en), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
        .i_set_default(cmd[0]), .i_field_on_cmd(cmd[1]),
        .i_tx_done(cmd[2]), .i_go_normal_cmd(cmd[3]),
        .i_detected_rate(4'h2), .i_ext_field_off(fld_off),
        .i_channel_pick(pick), .o_ready_mode(rdy), .o_rx_enable(rxe),
        .o_tx_enable(txe), .o_am_active(am), .o_pm_active(pm),
        .o_auto_chan_sel(aut), .o_wakeup_mode_on(wake),
        .o_target_role(targ), .o_protocol(proto), .o_tx_fraction(txf),
        .o_rx_fraction(rxf), .o_config_bad(bad), .o_collision_start(ca));
    rom_host_model rom_host_model_i (.i_mclk(i_mclk), .i_rdata(rdata),
        .o_wr_en(wr_en), .o_addr(addr), .o_wdata(wdata));
    // pulses are counted on the edge, the design's update lands after it
    always @(posedge i_mclk)
        if (ca)
            ca_cnt++;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        rom_host_model_i.wr(a, d);
    endtask
    task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
        rom_host_model_i.rd(a, rb);
        chk(rb, e);
    endtask
    // commands: 0 set-default, 1 field-on, 2 tx done, 3 go-normal
    task automatic pulse(input int b);
        @(posedge i_mclk);
        cmd[b] <= 1'b1;
        @(posedge i_mclk);
        cmd[b] <= 1'b0;
        repeat (3) @(posedge i_mclk);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // watchdog sized well above the roughly 290 cycles of stimulus
    initial
    begin
        #(20ns * 3000);
        err_total++;
        complete_run();
    end
    initial
    begin
        repeat (12) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        rdchk(ADDR_MODE_DEF, 8'h08);
        rdchk(ADDR_OP_CTRL, 8'h00);
        foreach (rows[k])
        begin
            wr(ADDR_OP_CTRL, rows[k].op);
            wr(ADDR_MODE_DEF, rows[k].md);
            wr(ADDR_RATE_DEF, rows[k].br);
            repeat (3) @(posedge i_mclk);
            #1;
            chk({rdy, wake, rxe, txe, am, pm, aut, bad}, rows[k].fl);
            chk(proto, rows[k].pr);
            chk({txf, rxf}, {rows[k].tf, rows[k].rf});
            chk(targ, rows[k].md[7]);
            rdchk(ADDR_OP_CTRL, rows[k].op & OP_USED_MASK);
        end
        // unmapped address takes nothing and reads zero
        wr(6'h05, 8'hA5);
        rdchk(6'h05, 8'h00);
        // set-default spares operation control only
        wr(ADDR_OP_CTRL, 8'h48);
        wr(ADDR_MODE_DEF, 8'h91);
        wr(ADDR_RATE_DEF, 8'h33);
        pulse(0);
        rdchk(ADDR_OP_CTRL, 8'h48);
        rdchk(ADDR_MODE_DEF, 8'h08);
        rdchk(ADDR_RATE_DEF, 8'h00);
        // field-on sets tx; tx done clears it only in peer mode
        wr(ADDR_OP_CTRL, 8'h40);
        pulse(1);
        rdchk(ADDR_OP_CTRL, 8'h48);
        chk(txe, 1'b1);
        pulse(2);
        rdchk(ADDR_OP_CTRL, 8'h48);
        wr(ADDR_MODE_DEF, 8'h00);
        pulse(2);
        rdchk(ADDR_OP_CTRL, 8'h40);
        pulse(3);
        rdchk(ADDR_RATE_DEF, 8'h22);
        // a single channel follows the pick input
        @(posedge i_mclk);
        pick <= 1'b1;
        wr(ADDR_OP_CTRL, 8'h68);
        repeat (3) @(posedge i_mclk);
        #1;
        chk({am, pm, aut}, 3'b010);
        // field loss starts collision avoidance only when enabled
        wr(ADDR_MODE_DEF, 8'h01);
        @(posedge i_mclk);
        fld_off <= 1'b1;
        repeat (4) @(posedge i_mclk);
        fld_off <= 1'b0;
        wr(ADDR_MODE_DEF, 8'h00);
        @(posedge i_mclk);
        fld_off <= 1'b1;
        repeat (4) @(posedge i_mclk);
        chk(ca_cnt, 1);
        // a second power-up reset restores the defaults
        @(posedge i_mclk);
        i_arst_n <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        rdchk(ADDR_OP_CTRL, 8'h00);
        rdchk(ADDR_RATE_DEF, 8'h00);
        complete_run();
    end
endmodule
